// ==== core/fpqc_defines.svh ====
// fpqc_defines.svh: offsets, fields, reset values and timing counts
// assumes inclusion by bare name before any module that uses them
`ifndef FPQC_DEFINES_SVH
`define FPQC_DEFINES_SVH
`define FPQC_ADDR_MODE      4'h0
`define FPQC_ADDR_RESTART   4'h1
`define FPQC_ADDR_STATUS    4'h2
`define FPQC_BANK0          2'h1
`define FPQC_BANK1          2'h2
`define FPQC_SUB_CTRL       2'h0
`define FPQC_SUB_PRESET     2'h1
`define FPQC_SUB_END        2'h2
`define FPQC_SUB_COUNT      2'h3
`define FPQC_CTRL_EN_BIT    0
`define FPQC_CTRL_DOWN_BIT  1
`define FPQC_CTRL_SET_BIT   2
`define FPQC_STAT_FLAG0_BIT 8
`define FPQC_STAT_FLAG1_BIT 9
`define FPQC_MODE_RST       8'h00
`define FPQC_WORD_RST       16'h0000
`define FPQC_COUNT_MAX      16'sh7FFF
`define FPQC_COUNT_MIN      16'sh8000
`define FPQC_CLK_HZ         100000000
`define FPQC_MAX_RATE_HZ    50000
`define FPQC_MIN_HALF_CYC   ((`FPQC_CLK_HZ / `FPQC_MAX_RATE_HZ) / 2)
`endif

// ==== core/fpqc_pkg.sv ====
// fpqc_pkg.sv: types shared by the counter
// assumes nothing beyond the defines header
package fpqc_pkg;
  typedef enum logic [7:0] {
    FPQC_MODE_NONE     = 8'h00,
    FPQC_MODE_SINGLE   = 8'h01,
    FPQC_MODE_GATED    = 8'h02,
    FPQC_MODE_DUAL     = 8'h03,
    FPQC_MODE_DUAL_INV = 8'h04,
    FPQC_MODE_SET_RISE = 8'h05,
    FPQC_MODE_SET_FALL = 8'h06,
    FPQC_MODE_QUAD     = 8'h07
  } fpqc_mode_e;
  typedef logic signed [15:0] fpqc_count_t;
endpackage

// ==== core/fpqc_counter.sv ====
// fpqc_counter.sv: fast pulse and quadrature counter, one clock domain
// assumes asynchronous pins and a one-cycle strobe register port
//
// What this block does
// - gated mode uses input zero to count, input one to gate, pin for end.
// - gated mode: gate controls counting and the end pin.
// - gated mode counts only with gate high and software enable set.
// - dual mode: counter 0 from input zero, counter 1 from input one.
// - dual, set and quadrature modes never drive the end pin.
// - direction change reloads the preset, then counts the new way except in single, gated and quadrature modes.
// - inverted dual mode: counter 1 counts falling edges of input one.
// - rising-edge set mode loads preset on rising edge only.
// - falling-edge set mode loads preset on falling edge only.
// - quadrature mode counts up or down by which track leads.
// - quadrature gives one count per full cycle, no multiplication.
// - quadrature uses tracks zero and one only, no index track.
// - count is 16-bit two's-complement signed.
// - pulse rates to 50 kHz count correctly; sources stay below.
// - mode byte decodes 00h to 07h; upper byte zero.
// - mode takes effect only at reset or restart.
// - count wraps 7FFFh to 8000h up and 8000h to 7FFFh down.
// - end flag sets on reaching end value, cleared by preset load.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "fpqc_defines.svh"
module fpqc_counter (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        fast_input_zero_in,
  input  wire logic        fast_input_one_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  output logic             limit_output_pin_out
);

  ////////////////////////////////////////////////////////////////////////
  // input synchroniser and filter
  logic [2:0] sync0_reg, sync0_next;
  logic [2:0] sync1_reg, sync1_next;
  logic [1:0] filt_reg, filt_next;
  logic [1:0] filt_d_reg, filt_d_next;
  logic [1:0] rise, fall;

  always_comb begin
    sync0_next  = {sync0_reg[1:0], fast_input_zero_in};
    sync1_next  = {sync1_reg[1:0], fast_input_one_in};
    filt_next   = filt_reg;
    filt_d_next = filt_reg;
    if (sync0_reg[1] == sync0_reg[2]) begin
      filt_next[0] = sync0_reg[2];
    end
    if (sync1_reg[1] == sync1_reg[2]) begin
      filt_next[1] = sync1_reg[2];
    end
    rise = filt_reg & ~filt_d_reg;
    fall = ~filt_reg & filt_d_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sync0_reg  <= 3'h0;
      sync1_reg  <= 3'h0;
      filt_reg   <= 2'h0;
      filt_d_reg <= 2'h0;
    end else begin
      sync0_reg  <= sync0_next;
      sync1_reg  <= sync1_next;
      filt_reg   <= filt_next;
      filt_d_reg <= filt_d_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode configuration
  logic [7:0]             mode_cfg_reg, mode_cfg_next;
  fpqc_pkg::fpqc_mode_e   mode_reg, mode_next;
  logic                   init_reg, init_next;

  always_comb begin
    mode_cfg_next = mode_cfg_reg;
    init_next     = 1'b0;
    mode_next     = mode_reg;
    if (reg_wr_in && reg_addr_in == `FPQC_ADDR_MODE) begin
      mode_cfg_next = reg_wdata_in[7:0];
    end
    if (reg_wr_in && reg_addr_in == `FPQC_ADDR_RESTART) begin
      init_next = 1'b1;
    end
    if (init_reg) begin
      case (mode_cfg_reg)
        8'h01:   mode_next = fpqc_pkg::FPQC_MODE_SINGLE;
        8'h02:   mode_next = fpqc_pkg::FPQC_MODE_GATED;
        8'h03:   mode_next = fpqc_pkg::FPQC_MODE_DUAL;
        8'h04:   mode_next = fpqc_pkg::FPQC_MODE_DUAL_INV;
        8'h05:   mode_next = fpqc_pkg::FPQC_MODE_SET_RISE;
        8'h06:   mode_next = fpqc_pkg::FPQC_MODE_SET_FALL;
        8'h07:   mode_next = fpqc_pkg::FPQC_MODE_QUAD;
        default: mode_next = fpqc_pkg::FPQC_MODE_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mode_cfg_reg <= `FPQC_MODE_RST;
      mode_reg     <= fpqc_pkg::FPQC_MODE_NONE;
      init_reg     <= 1'b1;
    end else begin
      mode_cfg_reg <= mode_cfg_next;
      mode_reg     <= mode_next;
      init_reg     <= init_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counting events and loads
  logic [1:0] en_reg, down_reg, flag_reg;
  logic [1:0] ev, dn, load, hit, ctrl_wr;

  always_comb begin
    hit[0]  = reg_addr_in[3:2] == `FPQC_BANK0;
    hit[1]  = reg_addr_in[3:2] == `FPQC_BANK1;
    ev      = 2'h0;
    dn      = down_reg;
    load    = 2'h0;
    for (int i = 0; i < 2; i++) begin
      ctrl_wr[i] = reg_wr_in && hit[i] &&
                   reg_addr_in[1:0] == `FPQC_SUB_CTRL;
      if (ctrl_wr[i] && (reg_wdata_in[`FPQC_CTRL_SET_BIT] ||
          reg_wdata_in[`FPQC_CTRL_DOWN_BIT] != down_reg[i])) begin
        load[i] = 1'b1;
      end
    end
    case (mode_reg)
      fpqc_pkg::FPQC_MODE_SINGLE: begin
        ev[0] = rise[0] && en_reg[0];
        dn[0] = 1'b0;
      end
      fpqc_pkg::FPQC_MODE_GATED: begin
        ev[0] = rise[0] && en_reg[0] && filt_reg[1];
        dn[0] = 1'b0;
      end
      fpqc_pkg::FPQC_MODE_DUAL: begin
        ev[0] = rise[0] && en_reg[0];
        ev[1] = rise[1] && en_reg[1];
      end
      fpqc_pkg::FPQC_MODE_DUAL_INV: begin
        ev[0] = rise[0] && en_reg[0];
        ev[1] = fall[1] && en_reg[1];
      end
      fpqc_pkg::FPQC_MODE_SET_RISE: begin
        ev[0] = rise[0] && en_reg[0];
        if (rise[1]) begin
          load[0] = 1'b1;
        end
      end
      fpqc_pkg::FPQC_MODE_SET_FALL: begin
        ev[0] = rise[0] && en_reg[0];
        if (fall[1]) begin
          load[0] = 1'b1;
        end
      end
      fpqc_pkg::FPQC_MODE_QUAD: begin
        ev[0] = rise[0] && en_reg[0];
        dn[0] = filt_reg[1];
      end
      default: begin
        ev = 2'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // counters and per-counter registers
  fpqc_pkg::fpqc_count_t count_reg [2];
  fpqc_pkg::fpqc_count_t count_next [2];
  logic [15:0]           preset_reg [2];
  logic [15:0]           preset_next [2];
  logic [15:0]           end_reg [2];
  logic [15:0]           end_next [2];
  logic [1:0]            en_next, down_next, flag_next;
  fpqc_pkg::fpqc_count_t step [2];

  always_comb begin
    en_next   = en_reg;
    down_next = down_reg;
    flag_next = flag_reg;
    for (int i = 0; i < 2; i++) begin
      count_next[i]  = count_reg[i];
      preset_next[i] = preset_reg[i];
      end_next[i]    = end_reg[i];
      step[i] = dn[i] ? count_reg[i] - 16'sh0001
                      : count_reg[i] + 16'sh0001;
      if (ctrl_wr[i]) begin
        en_next[i]   = reg_wdata_in[`FPQC_CTRL_EN_BIT];
        down_next[i] = reg_wdata_in[`FPQC_CTRL_DOWN_BIT];
      end
      if (reg_wr_in && hit[i] &&
          reg_addr_in[1:0] == `FPQC_SUB_PRESET) begin
        preset_next[i] = reg_wdata_in;
      end
      if (reg_wr_in && hit[i] && reg_addr_in[1:0] == `FPQC_SUB_END) begin
        end_next[i] = reg_wdata_in;
      end
      if (load[i]) begin
        count_next[i] = preset_reg[i];
        flag_next[i]  = 1'b0;
      end else if (ev[i]) begin
        count_next[i] = step[i];
        if (step[i] == end_reg[i]) begin
          flag_next[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      en_reg   <= 2'h0;
      down_reg <= 2'h0;
      flag_reg <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        count_reg[i]  <= `FPQC_WORD_RST;
        preset_reg[i] <= `FPQC_WORD_RST;
        end_reg[i]    <= `FPQC_WORD_RST;
      end
    end else begin
      en_reg   <= en_next;
      down_reg <= down_next;
      flag_reg <= flag_next;
      for (int i = 0; i < 2; i++) begin
        count_reg[i]  <= count_next[i];
        preset_reg[i] <= preset_next[i];
        end_reg[i]    <= end_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // end pin and register read port
  logic        pin_next, pin_reg;
  logic [15:0] rdata_next, rdata_reg;
  logic [1:0]  bank;

  always_comb begin
    pin_next = 1'b0;
    if (mode_reg == fpqc_pkg::FPQC_MODE_SINGLE) begin
      pin_next = flag_reg[0] && en_reg[0];
    end else if (mode_reg == fpqc_pkg::FPQC_MODE_GATED) begin
      pin_next = flag_reg[0] && en_reg[0] && filt_reg[1];
    end
    bank       = reg_addr_in[3:2];
    rdata_next = 16'h0000;
    if (reg_rd_in) begin
      if (reg_addr_in == `FPQC_ADDR_MODE) begin
        rdata_next = {8'h00, mode_cfg_reg};
      end else if (reg_addr_in == `FPQC_ADDR_STATUS) begin
        rdata_next = {6'h00, flag_reg, mode_reg};
      end else if (bank == `FPQC_BANK0 || bank == `FPQC_BANK1) begin
        case (reg_addr_in[1:0])
          `FPQC_SUB_CTRL: begin
            rdata_next = {14'h0000, down_reg[bank[1]], en_reg[bank[1]]};
          end
          `FPQC_SUB_PRESET: rdata_next = preset_reg[bank[1]];
          `FPQC_SUB_END:    rdata_next = end_reg[bank[1]];
          default:          rdata_next = count_reg[bank[1]];
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      pin_reg   <= pin_next;
      rdata_reg <= rdata_next;
    end
  end

  assign limit_output_pin_out = pin_reg;
  assign reg_rdata_out        = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_count_read;
    reg_rd_in && reg_addr_in == {`FPQC_BANK0, `FPQC_SUB_COUNT};
  endsequence

  property p_read_count;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_count_read |=> reg_rdata_out == $past(count_reg[0]);
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("count read mismatch");

  property p_gate_blocks;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_GATED && !filt_reg[1] && !load[0]
      |=> count_reg[0] == $past(count_reg[0]);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks)
    else $error("gated counter moved with gate low");

  property p_pin_gate;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_GATED && !filt_reg[1]
      |=> !limit_output_pin_out;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("end pin driven with gate low");

  property p_pin_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg != fpqc_pkg::FPQC_MODE_SINGLE &&
    mode_reg != fpqc_pkg::FPQC_MODE_GATED ##1
    $stable(mode_reg) |-> !limit_output_pin_out;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet)
    else $error("end pin driven in flag-only mode");

  property p_dual_one;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_DUAL && rise[1] && en_reg[1] &&
    !down_reg[1] && !load[1]
      |=> count_reg[1] == $past(count_reg[1]) + 16'sh0001;
  endproperty
  a_dual_one: assert property (p_dual_one)
    else $error("counter 1 missed a rising edge");

  property p_inv_rise;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_DUAL_INV && rise[1] && !load[1]
      |=> count_reg[1] == $past(count_reg[1]);
  endproperty
  a_inv_rise: assert property (p_inv_rise)
    else $error("inverted counter counted a rising edge");

  property p_set_edge;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_SET_RISE && rise[1]
      |=> count_reg[0] == $past(preset_reg[0]) && !flag_reg[0];
  endproperty
  a_set_edge: assert property (p_set_edge)
    else $error("rising set edge did not load preset");

  property p_quad_single;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_QUAD && !rise[0] && !load[0]
      |=> count_reg[0] == $past(count_reg[0]);
  endproperty
  a_quad_single: assert property (p_quad_single)
    else $error("quadrature counted off the track A rise");

  property p_quad_up;
    @(posedge clk_sys_in) disable iff (rst_in)
    mode_reg == fpqc_pkg::FPQC_MODE_QUAD && rise[0] && en_reg[0] &&
    !filt_reg[1] && !load[0]
      |=> count_reg[0] == $past(count_reg[0]) + 16'sh0001;
  endproperty
  a_quad_up: assert property (p_quad_up)
    else $error("quadrature failed to count up");

  property p_wrap_up;
    @(posedge clk_sys_in) disable iff (rst_in)
    ev[0] && !dn[0] && !load[0] && count_reg[0] == `FPQC_COUNT_MAX
      |=> count_reg[0] == `FPQC_COUNT_MIN;
  endproperty
  a_wrap_up: assert property (p_wrap_up)
    else $error("count did not wrap upward");

  property p_flag_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    flag_reg[0] && !load[0] |=> flag_reg[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("end flag dropped without load");

  property p_dir_reload;
    @(posedge clk_sys_in) disable iff (rst_in)
    ctrl_wr[0] && reg_wdata_in[`FPQC_CTRL_DOWN_BIT] != down_reg[0]
      |=> count_reg[0] == $past(preset_reg[0]);
  endproperty
  a_dir_reload: assert property (p_dir_reload)
    else $error("direction change did not reload preset");

  property p_mode_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    !init_reg |=> mode_reg == $past(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed outside start");

endmodule // fpqc_counter

// ==== dv/fpqc_pulse_src.sv ====
// fpqc_pulse_src.sv: pulse sources and two-track position sensor model
// assumes the bench calls its tasks; half_cyc starts at the rated minimum
`timescale 1ns/100ps
`include "fpqc_defines.svh"
module fpqc_pulse_src (
  input  wire logic clk_sys_in,
  output logic      track_a_out,
  output logic      track_b_out
);
  // cycles per level; pulse rate never above the rated counting rate
  int half_cyc = `FPQC_MIN_HALF_CYC;

  initial begin
    track_a_out = 1'b0;
    track_b_out = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // one step on both lines, held for half_cyc
  task automatic drive(input logic a, input logic b);
    @(posedge clk_sys_in);
    track_a_out <= a;
    track_b_out <= b;
    repeat (half_cyc) @(posedge clk_sys_in);
  endtask

  task automatic level(input bit line, input logic v);
    if (line) begin
      drive(track_a_out, v);
    end else begin
      drive(v, track_b_out);
    end
  endtask

  task automatic pulse(input bit line, input int n);
    repeat (n) begin
      level(line, 1'b1);
      level(line, 1'b0);
    end
  endtask

  // full cycles, tracks 90 degrees apart, a leads when up
  task automatic quad(input bit up, input int n);
    repeat (n) begin
      drive(up, !up);
      drive(1'b1, 1'b1);
      drive(!up, up);
      drive(1'b0, 1'b0);
    end
  endtask
endmodule // fpqc_pulse_src

// ==== dv/testbench.sv ====
// testbench.sv: register-level tests of the counter in every mode
// assumes the pulse source model and the defines header
`timescale 1ns/100ps
`include "fpqc_defines.svh"
module testbench;
  logic        clk_sys_in;
  logic        rst_in;
  logic        in0;
  logic        in1;
  logic [3:0]  reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [15:0] reg_rdata_out;
  logic        limit_output_pin_out;
  logic [15:0] rdv;
  int          fail_count = 0;
  int          check_count = 0;
  localparam logic [3:0] CNT0 = {`FPQC_BANK0, `FPQC_SUB_COUNT};
  localparam logic [3:0] CNT1 = {`FPQC_BANK1, `FPQC_SUB_COUNT};
  localparam logic [3:0] CTL0 = {`FPQC_BANK0, `FPQC_SUB_CTRL};

  fpqc_counter dut (
    .clk_sys_in           (clk_sys_in),
    .rst_in               (rst_in),
    .fast_input_zero_in   (in0),
    .fast_input_one_in    (in1),
    .reg_addr_in          (reg_addr_in),
    .reg_wdata_in         (reg_wdata_in),
    .reg_wr_in            (reg_wr_in),
    .reg_rd_in            (reg_rd_in),
    .reg_rdata_out        (reg_rdata_out),
    .limit_output_pin_out (limit_output_pin_out)
  );

  fpqc_pulse_src src (
    .clk_sys_in  (clk_sys_in),
    .track_a_out (in0),
    .track_b_out (in1)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  //////////////////////////////////////////////////////////////////////
  // compare, bus access and setup tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    rdv = reg_rdata_out;
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    check(rdv, e);
  endtask

  task automatic pin(input logic e);
    #1;
    check({15'h0000, limit_output_pin_out}, {15'h0000, e});
  endtask

  task automatic flag(input int b, input logic e);
    rd(`FPQC_ADDR_STATUS);
    check({15'h0000, rdv[b]}, {15'h0000, e});
  endtask

  task automatic set_mode(input logic [7:0] m);
    wr(`FPQC_ADDR_MODE, {8'h00, m});
    wr(`FPQC_ADDR_RESTART, 16'h0000);
    rd(`FPQC_ADDR_STATUS);
    check({8'h00, rdv[7:0]}, {8'h00, m});
  endtask

  task automatic setup(input logic [1:0] b, input logic [15:0] p,
                       input logic [15:0] e, input logic dn);
    logic [15:0] c;
    c = 16'h0000;
    c[`FPQC_CTRL_EN_BIT] = 1'b1;
    c[`FPQC_CTRL_SET_BIT] = 1'b1;
    c[`FPQC_CTRL_DOWN_BIT] = dn;
    wr({b, `FPQC_SUB_PRESET}, p);
    wr({b, `FPQC_SUB_END}, e);
    wr({b, `FPQC_SUB_CTRL}, c);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (90000) @(posedge clk_sys_in);
    fail_count++;
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    rst_in = 1'b1;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rc(`FPQC_ADDR_STATUS, 16'h0000);
    wr(4'h3, 16'hFFFF);
    rc(4'h3, 16'h0000);
    wr(`FPQC_ADDR_MODE, 16'h0002);
    rc(`FPQC_ADDR_STATUS, 16'h0000);
    // gated up-counter
    set_mode(8'h02);
    setup(`FPQC_BANK0, 16'h0000, 16'h0003, 1'b0);
    src.pulse(0, 2);
    rc(CNT0, 16'h0000);
    src.level(1, 1'b1);
    src.pulse(0, 2);
    rc(CNT0, 16'h0002);
    rc(CNT0, 16'h0002);
    pin(1'b0);
    src.pulse(0, 1);
    rc(CNT0, 16'h0003);
    flag(`FPQC_STAT_FLAG0_BIT, 1'b1);
    pin(1'b1);
    src.level(1, 1'b0);
    pin(1'b0);
    wr(CTL0, 16'h0000);
    src.level(1, 1'b1);
    src.pulse(0, 2);
    rc(CNT0, 16'h0003);
    src.level(1, 1'b0);
    // dual up/down counters, wrap and direction change
    set_mode(8'h03);
    setup(`FPQC_BANK0, 16'h7FFE, 16'h1234, 1'b0);
    setup(`FPQC_BANK1, 16'h8001, 16'h8000, 1'b1);
    src.pulse(0, 2);
    src.pulse(1, 1);
    rc(CNT0, 16'h8000);
    rc(CNT1, 16'h8000);
    flag(`FPQC_STAT_FLAG1_BIT, 1'b1);
    pin(1'b0);
    src.pulse(1, 1);
    rc(CNT1, 16'h7FFF);
    wr({`FPQC_BANK1, `FPQC_SUB_CTRL}, 16'h0001);
    src.pulse(1, 1);
    rc(CNT1, 16'h8002);
    wr(CTL0, 16'h0003);
    src.pulse(0, 1);
    rc(CNT0, 16'h7FFD);
    src.half_cyc = `FPQC_MIN_HALF_CYC;
    src.pulse(0, 3);
    rc(CNT0, 16'h7FFA);
    // second counter on falling edges
    set_mode(8'h04);
    setup(`FPQC_BANK1, 16'h0000, 16'h7FFF, 1'b0);
    src.level(1, 1'b1);
    rc(CNT1, 16'h0000);
    src.level(1, 1'b0);
    rc(CNT1, 16'h0001);
    // edge-triggered set, rising then falling
    for (int i = 0; i < 2; i++) begin
      set_mode(i ? 8'h06 : 8'h05);
      setup(`FPQC_BANK0, 16'h0064, 16'h0065, 1'b0);
      src.pulse(0, 2);
      src.level(1, 1'b1);
      rc(CNT0, i ? 16'h0066 : 16'h0064);
      src.pulse(0, 1);
      rc(CNT0, i ? 16'h0067 : 16'h0065);
      pin(1'b0);
      src.level(1, 1'b0);
      rc(CNT0, i ? 16'h0064 : 16'h0065);
      flag(`FPQC_STAT_FLAG0_BIT, i ? 1'b0 : 1'b1);
    end
    // two-track position sensor
    set_mode(8'h07);
    setup(`FPQC_BANK0, 16'h0000, 16'h0002, 1'b0);
    src.quad(1, 3);
    rc(CNT0, 16'h0003);
    src.quad(0, 2);
    rc(CNT0, 16'h0001);
    pin(1'b0);
    // single up-counter ignores the down bit
    set_mode(8'h01);
    setup(`FPQC_BANK0, 16'h0000, 16'h0001, 1'b1);
    src.pulse(0, 1);
    rc(CNT0, 16'h0001);
    pin(1'b1);
    finish_test();
  end
endmodule // testbench
